// [src/ccs_consts.svh]
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// register offsets
`define CCS_ADDR_TERM_TIMER      8'h05
`define CCS_ADDR_INPUT_PROT      8'h06
`define CCS_ADDR_SWITCH_DETECT   8'h07
`define CCS_ADDR_STATUS          8'h08
`define CCS_ADDR_RESET_CTRL      8'h0b

// reset values
`define CCS_RST_TERM_TIMER       8'h9f
`define CCS_RST_INPUT_PROT       8'h66
`define CCS_RST_SWITCH_DETECT    8'h4c

// fields that the host watchdog also restores
`define CCS_WD_MASK_TERM_TIMER   8'hff
`define CCS_WD_MASK_INPUT_PROT   8'h00
`define CCS_WD_MASK_SWITCH_DET   8'hd4

// termination/timer control fields
`define CCS_BIT_TERM_EN          7
`define CCS_BIT_WD_HI            5
`define CCS_BIT_WD_LO            4
`define CCS_BIT_SAFETY_EN        3
`define CCS_BIT_FAST_LIMIT       2
`define CCS_BIT_THERM_SEL        1
`define CCS_BIT_COLD_ISET        0

// input protection fields
`define CCS_BIT_OVP_HI           7
`define CCS_BIT_OVP_LO           6
`define CCS_BIT_BOOST_HI         5
`define CCS_BIT_BOOST_LO         4
`define CCS_BIT_VLIM_HI          3
`define CCS_BIT_VLIM_LO          0

// switch/detect fields
`define CCS_BIT_DETECT_FORCE     7
`define CCS_BIT_SLOWDOWN_EN      6
`define CCS_BIT_SWITCH_DIS       5
`define CCS_BIT_WARM_VSEL        4
`define CCS_BIT_SWITCH_DLY       3
`define CCS_BIT_SWITCH_RST_EN    2
`define CCS_BIT_TRACK_HI         1
`define CCS_BIT_TRACK_LO         0

// reset control
`define CCS_BIT_REG_RESET        7

// times
`define CCS_CLK_HZ               125000000
`define CCS_WD_SHORT_S           8'd40
`define CCS_WD_MID_S             8'd80
`define CCS_WD_LONG_S            8'd160
`define CCS_SWITCH_DLY_S         8'd10

// voltages in mV
`define CCS_VLIM_BASE_MV         14'd3900
`define CCS_VLIM_STEP_MV         14'd100
`define CCS_TRACK_200_MV         14'd200
`define CCS_TRACK_250_MV         14'd250
`define CCS_TRACK_300_MV         14'd300

`endif

// [src/ccs_pkg.sv]
package ccs_pkg;
	typedef enum logic [1:0] {
		CCS_WD_OFF   = 2'h0,
		CCS_WD_SHORT = 2'h1,
		CCS_WD_MID   = 2'h2,
		CCS_WD_LONG  = 2'h3
	} ccs_wd_period_t;

	// battery switch path, gray along on->wait->off
	typedef enum logic [1:0] {
		CCS_SW_ON   = 2'h0,
		CCS_SW_WAIT = 2'h1,
		CCS_SW_OFF  = 2'h3
	} ccs_sw_state_t;
endpackage

// [src/ccs_regs.sv]
// How it works
// - bit 7 enables termination, default on
// - watchdog code: off, 40, 80, 160 s
// - watchdog restores only its marked fields
// - one bit enables both safety timers
// - fast-charge limit: 0=5h, 1=10h
// - overvoltage code selects four thresholds
// - voltage limit 3.9V plus 100mV steps
// - detect force starts detection, self-clears
// - slowdown halves safety timer while input limiting, in thermal regulation or in cool zone
// - switch disable bit turns switch off
// - delay select: immediate or 10 s
// - warm zone caps voltage unless bit set
// - switch reset enable bit passed out
// - effective limit is max(reg, vbat+offset) with tracking on, reg alone with tracking off
// - input source status reported read-only
// - charge state reported read-only
// - thermal regulation flag read-only
// - system minimum flag read-only
// - register reset restores defaults, self-clears
`timescale 1ns/100ps
`include "ccs_consts.svh"
module ccs_regs
	import ccs_pkg::*;
#(
	parameter int TICKS_PER_SEC = `CCS_CLK_HZ
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// register port from the serial bus engine
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rd_valid,
	// live conditions from the charger core
	input  wire logic        input_power_present,
	input  wire logic        detect_done,
	input  wire logic [2:0]  input_source_status,
	input  wire logic [1:0]  charge_state_status,
	input  wire logic        power_good_flag,
	input  wire logic        thermal_regulation_flag,
	input  wire logic        system_minimum_flag,
	input  wire logic        input_limit_active,
	input  wire logic        cool_zone,
	input  wire logic        warm_zone,
	input  wire logic [12:0] battery_mv,
	// settings to the charger core
	output logic             term_enable,
	output logic             safety_timer_enable,
	output logic             fast_charge_limit_select,
	output logic             thermal_threshold_select,
	output logic             cold_zone_current_select,
	output logic      [1:0]  input_overvoltage_select,
	output logic      [1:0]  boost_voltage_select,
	output logic      [3:0]  input_voltage_limit,
	output logic      [13:0] effective_vin_limit_mv,
	output logic             safety_timer_half_rate,
	output logic             warm_voltage_cap,
	output logic             battery_switch_reset_enable,
	output logic             battery_switch_off,
	output logic             input_detect_start,
	output logic             safety_timer_reset,
	output logic             watchdog_expired
);
	localparam int PW = $clog2(TICKS_PER_SEC + 1);
	// default images, sliced so the direct field outputs reset to agree with the register defaults
	localparam logic [7:0] TT_RST = `CCS_RST_TERM_TIMER;
	localparam logic [7:0] IP_RST = `CCS_RST_INPUT_PROT;
	localparam logic [7:0] SD_RST = `CCS_RST_SWITCH_DETECT;

	generate
		if (TICKS_PER_SEC < 1) begin : g_chk
			$error("ccs_regs: TICKS_PER_SEC must be at least 1");
		end
	endgenerate

	logic [7:0]    term_timer_q;
	logic [7:0]    term_timer_d;
	logic [7:0]    input_prot_q;
	logic [7:0]    input_prot_d;
	logic [7:0]    switch_det_q;
	logic [7:0]    switch_det_d;
	logic [PW-1:0] presc_q;
	logic          sec_tick_q;
	logic          sw_dis_prev_q;
	ccs_sw_state_t sw_state_q;
	ccs_sw_state_t sw_state_d;

	// ---------------- decode ----------------
	wire wr_term   = reg_wr_en && (reg_addr == `CCS_ADDR_TERM_TIMER);
	wire wr_prot   = reg_wr_en && (reg_addr == `CCS_ADDR_INPUT_PROT);
	wire wr_switch = reg_wr_en && (reg_addr == `CCS_ADDR_SWITCH_DETECT);
	wire wr_rstc   = reg_wr_en && (reg_addr == `CCS_ADDR_RESET_CTRL);

	wire reg_reset_req = wr_rstc && reg_wdata[`CCS_BIT_REG_RESET];

	wire wd_expire;

	// ---------------- watchdog ----------------
	// period decode
	wire [1:0] wd_code = term_timer_q[`CCS_BIT_WD_HI:`CCS_BIT_WD_LO];
	wire [7:0] wd_seconds =
		(wd_code == CCS_WD_SHORT) ? `CCS_WD_SHORT_S :
		(wd_code == CCS_WD_MID)   ? `CCS_WD_MID_S   :
		(wd_code == CCS_WD_LONG)  ? `CCS_WD_LONG_S  : 8'h00;
	wire [1:0] wd_code_next = term_timer_d[`CCS_BIT_WD_HI:`CCS_BIT_WD_LO];
	wire [7:0] wd_seconds_next =
		(wd_code_next == CCS_WD_SHORT) ? `CCS_WD_SHORT_S :
		(wd_code_next == CCS_WD_MID)   ? `CCS_WD_MID_S   :
		(wd_code_next == CCS_WD_LONG)  ? `CCS_WD_LONG_S  : 8'h00;

	// any host write restarts the period
	wire wd_kick = reg_wr_en || reg_reset_req || wd_expire;

	ccs_sec_counter #(
		.W (8)
	) u_watchdog (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.load     (wd_kick || (wd_seconds_next != wd_seconds)),
		.load_val (wd_seconds_next),
		.tick     (sec_tick_q),
		.done     (wd_expire)
	);

	// ---------------- register next values ----------------
	// reset sources: register reset hits every field, watchdog only marked ones
	function automatic logic [7:0] restore(
		input logic [7:0] cur,
		input logic [7:0] dflt,
		input logic [7:0] wd_mask,
		input logic       full,
		input logic       wd
	);
		logic [7:0] res;
		res = cur;
		if (full) begin
			res = dflt;
		end else if (wd) begin
			res = (cur & ~wd_mask) | (dflt & wd_mask);
		end
		return res;
	endfunction

	// written straight into the control byte
	always_comb begin
		term_timer_d = term_timer_q;
		if (wr_term) begin
			term_timer_d = reg_wdata;
		end
		term_timer_d = restore(term_timer_d, `CCS_RST_TERM_TIMER, `CCS_WD_MASK_TERM_TIMER,
			reg_reset_req, wd_expire);
	end

	always_comb begin
		input_prot_d = input_prot_q;
		if (wr_prot) begin
			input_prot_d = reg_wdata;
		end
		input_prot_d = restore(input_prot_d, `CCS_RST_INPUT_PROT, `CCS_WD_MASK_INPUT_PROT,
			reg_reset_req, wd_expire);
	end

	// force bit needs input power; hardware clears on done, host set wins
	wire detect_set = wr_switch && reg_wdata[`CCS_BIT_DETECT_FORCE] && input_power_present
		&& !switch_det_q[`CCS_BIT_DETECT_FORCE];

	always_comb begin
		switch_det_d = switch_det_q;
		if (detect_done) begin
			switch_det_d[`CCS_BIT_DETECT_FORCE] = 1'b0;
		end
		if (wr_switch) begin
			switch_det_d[6:0] = reg_wdata[6:0];
			if (reg_wdata[`CCS_BIT_DETECT_FORCE] && input_power_present) begin
				switch_det_d[`CCS_BIT_DETECT_FORCE] = 1'b1;
			end
		end
		switch_det_d = restore(switch_det_d, `CCS_RST_SWITCH_DETECT, `CCS_WD_MASK_SWITCH_DET,
			reg_reset_req, wd_expire);
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			term_timer_q <= `CCS_RST_TERM_TIMER;
			input_prot_q <= `CCS_RST_INPUT_PROT;
			switch_det_q <= `CCS_RST_SWITCH_DETECT;
		end else begin
			term_timer_q <= term_timer_d;
			input_prot_q <= input_prot_d;
			switch_det_q <= switch_det_d;
		end
	end

	// ---------------- one-second enable ----------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			presc_q    <= '0;
			sec_tick_q <= 1'b0;
		end else if (presc_q == PW'(TICKS_PER_SEC - 1)) begin
			presc_q    <= '0;
			sec_tick_q <= 1'b1;
		end else begin
			presc_q    <= presc_q + 1'b1;
			sec_tick_q <= 1'b0;
		end
	end

	// ---------------- battery switch ----------------
	wire sw_dis     = switch_det_q[`CCS_BIT_SWITCH_DIS];
	wire sw_dly_sel = switch_det_q[`CCS_BIT_SWITCH_DLY];
	wire sw_dis_rise = sw_dis && !sw_dis_prev_q;
	wire sw_delay_done;

	// delay restarts on every fresh disable
	ccs_sec_counter #(
		.W (8)
	) u_switch_delay (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.load     (sw_dis_rise || !sw_dis),
		.load_val (sw_dis ? `CCS_SWITCH_DLY_S : 8'h00),
		.tick     (sec_tick_q),
		.done     (sw_delay_done)
	);

	// disable turns off, clear allows on again
	always_comb begin
		sw_state_d = sw_state_q;
		case (sw_state_q)
			CCS_SW_ON: begin
				// immediate when delay select is 0
				if (sw_dis_rise) begin
					sw_state_d = sw_dly_sel ? CCS_SW_WAIT : CCS_SW_OFF;
				end
			end
			CCS_SW_WAIT: begin
				if (!sw_dis) begin
					sw_state_d = CCS_SW_ON;
				end else if (sw_delay_done) begin
					sw_state_d = CCS_SW_OFF;
				end
			end
			CCS_SW_OFF: begin
				if (!sw_dis) begin
					sw_state_d = CCS_SW_ON;
				end
			end
			default: begin
				sw_state_d = CCS_SW_ON;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sw_state_q    <= CCS_SW_ON;
			sw_dis_prev_q <= 1'b0;
		end else begin
			sw_state_q    <= sw_state_d;
			sw_dis_prev_q <= sw_dis;
		end
	end

	// ---------------- input voltage limit ----------------
	// threshold in mV
	wire [3:0]  vlim_code = input_prot_q[`CCS_BIT_VLIM_HI:`CCS_BIT_VLIM_LO];
	wire [13:0] vlim_reg_mv = 14'(`CCS_VLIM_BASE_MV + 14'(vlim_code) * `CCS_VLIM_STEP_MV);

	// tracking offset and larger of the two
	wire [1:0]  track_code = switch_det_q[`CCS_BIT_TRACK_HI:`CCS_BIT_TRACK_LO];
	wire [13:0] track_off_mv =
		(track_code == 2'h1) ? `CCS_TRACK_200_MV :
		(track_code == 2'h2) ? `CCS_TRACK_250_MV :
		(track_code == 2'h3) ? `CCS_TRACK_300_MV : 14'h0000;
	wire [13:0] track_mv = 14'({1'b0, battery_mv} + track_off_mv);
	wire        track_on = (track_code != 2'h0);
	wire [13:0] vlim_eff_mv = (track_on && (track_mv > vlim_reg_mv)) ? track_mv : vlim_reg_mv;

	// ---------------- status and read path ----------------
	// live status, nothing stored
	wire [7:0] status_byte = {input_source_status, charge_state_status, power_good_flag,
		thermal_regulation_flag, system_minimum_flag};

	// status has no write decode; reading it changes nothing
	wire [7:0] rd_mux =
		(reg_addr == `CCS_ADDR_TERM_TIMER)    ? term_timer_q :
		(reg_addr == `CCS_ADDR_INPUT_PROT)    ? input_prot_q :
		(reg_addr == `CCS_ADDR_SWITCH_DETECT) ? switch_det_q :
		(reg_addr == `CCS_ADDR_STATUS)        ? status_byte  : 8'h00;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata    <= 8'h00;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata <= rd_mux;
			end
		end
	end

	// ---------------- registered outputs ----------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			term_enable                 <= TT_RST[`CCS_BIT_TERM_EN];
			safety_timer_enable         <= TT_RST[`CCS_BIT_SAFETY_EN];
			fast_charge_limit_select    <= TT_RST[`CCS_BIT_FAST_LIMIT];
			thermal_threshold_select    <= TT_RST[`CCS_BIT_THERM_SEL];
			cold_zone_current_select    <= TT_RST[`CCS_BIT_COLD_ISET];
			input_overvoltage_select    <= IP_RST[`CCS_BIT_OVP_HI:`CCS_BIT_OVP_LO];
			boost_voltage_select        <= IP_RST[`CCS_BIT_BOOST_HI:`CCS_BIT_BOOST_LO];
			input_voltage_limit         <= IP_RST[`CCS_BIT_VLIM_HI:`CCS_BIT_VLIM_LO];
			effective_vin_limit_mv      <= 14'h0000;
			safety_timer_half_rate      <= 1'b0;
			warm_voltage_cap            <= 1'b0;
			battery_switch_reset_enable <= SD_RST[`CCS_BIT_SWITCH_RST_EN];
			battery_switch_off          <= 1'b0;
			input_detect_start          <= 1'b0;
			safety_timer_reset          <= 1'b0;
			watchdog_expired            <= 1'b0;
		end else begin
			term_enable <= term_timer_q[`CCS_BIT_TERM_EN];
			safety_timer_enable <= term_timer_q[`CCS_BIT_SAFETY_EN];
			fast_charge_limit_select <= term_timer_q[`CCS_BIT_FAST_LIMIT];
			thermal_threshold_select <= term_timer_q[`CCS_BIT_THERM_SEL];
			cold_zone_current_select <= term_timer_q[`CCS_BIT_COLD_ISET];
			input_overvoltage_select <= input_prot_q[`CCS_BIT_OVP_HI:`CCS_BIT_OVP_LO];
			boost_voltage_select <= input_prot_q[`CCS_BIT_BOOST_HI:`CCS_BIT_BOOST_LO];
			input_voltage_limit <= vlim_code;
			effective_vin_limit_mv <= vlim_eff_mv;
			safety_timer_half_rate <= switch_det_q[`CCS_BIT_SLOWDOWN_EN]
				&& (input_limit_active || cool_zone || thermal_regulation_flag);
			warm_voltage_cap <= warm_zone && !switch_det_q[`CCS_BIT_WARM_VSEL];
			battery_switch_reset_enable <= switch_det_q[`CCS_BIT_SWITCH_RST_EN];
			battery_switch_off <= (sw_state_d == CCS_SW_OFF);
			input_detect_start <= detect_set;
			// safety timer restarts with register reset
			safety_timer_reset <= reg_reset_req;
			watchdog_expired <= wd_expire;
		end
	end
endmodule

// [src/ccs_sec_counter.sv]
`timescale 1ns/100ps
module ccs_sec_counter #(
	parameter int W = 8
) (
	input  wire logic         sys_clk,
	input  wire logic         reset,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         tick,
	output logic              done
);
	logic [W-1:0] cnt_q;
	logic         run_q;

	generate
		if (W < 2) begin : g_chk
			$error("ccs_sec_counter: W too small");
		end
	endgenerate

	// a zero load stops the counter without a done pulse
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				cnt_q <= load_val;
				run_q <= (load_val != '0);
			end else if (run_q && tick) begin
				cnt_q <= cnt_q - 1'b1;
				if (cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
					run_q <= 1'b0;
					done  <= 1'b1;
				end
			end
		end
	end
endmodule

// [testbench/ccs_core_model.sv]
`timescale 1ns/100ps
module ccs_core_model (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic input_detect_start,
	input  wire logic slow,
	output logic      detect_done
);
	logic [4:0] cnt_q;
	// detection runs a while, then one done pulse
	always_ff @(posedge sys_clk) begin
		if (reset || input_detect_start)
			cnt_q <= reset ? 5'h0 : (slow ? 5'h14 : 5'h2);
		else if (cnt_q != 5'h0)
			cnt_q <= cnt_q - 5'h1;
	end
	assign detect_done = (cnt_q == 5'h1);
endmodule

// [testbench/ccs_regs_props.sv]
`timescale 1ns/100ps
module ccs_regs_props (
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic       reg_wr_en,
	input wire logic       reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rd_valid,
	input wire logic       input_power_present,
	input wire logic [2:0] input_source_status,
	input wire logic [1:0] charge_state_status,
	input wire logic       power_good_flag,
	input wire logic       thermal_regulation_flag,
	input wire logic       system_minimum_flag,
	input wire logic       term_enable,
	input wire logic [1:0] input_overvoltage_select,
	input wire logic       input_detect_start,
	input wire logic       safety_timer_reset,
	input wire logic       watchdog_expired
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire w5 = reg_wr_en && reg_addr == 8'h05;
	wire w6 = reg_wr_en && reg_addr == 8'h06;
	wire w7f = reg_wr_en && reg_addr == 8'h07 && reg_wdata[7];
	wire wrst = reg_wr_en && reg_addr == 8'h0b && reg_wdata[7];
	wire [7:0] live = {input_source_status, charge_state_status, power_good_flag, thermal_regulation_flag,
		system_minimum_flag};

	a_read_valid: assert property (reg_rd_en |=> reg_rd_valid) else $error("read not answered");
	a_status_live: assert property (reg_rd_en && reg_addr == 8'h08 |=> reg_rdata == $past(live))
		else $error("status read mismatch");
	a_term_write: assert property (w5 ##1 !reg_wr_en |=> term_enable == $past(reg_wdata[7], 2))
		else $error("termination enable not applied");
	a_ovp_write: assert property (w6 ##1 !reg_wr_en |=> input_overvoltage_select == $past(reg_wdata[7:6], 2))
		else $error("overvoltage select not applied");
	a_force_start: assert property (w7f && input_power_present |=> input_detect_start)
		else $error("detection not started");
	a_force_refuse: assert property (w7f && !input_power_present |=> !input_detect_start)
		else $error("detection started without power");
	a_regrst_pulse: assert property (wrst |-> ##[1:2] safety_timer_reset)
		else $error("safety timer reset missing");
	a_regrst_term: assert property (wrst ##1 !reg_wr_en [*2] |=> term_enable)
		else $error("default not restored");
	a_wd_keep: assert property (watchdog_expired |-> ##1 term_enable && $stable(input_overvoltage_select))
		else $error("watchdog restore wrong");

	c_status: cover property (reg_rd_en && reg_addr == 8'h08);
	c_detect: cover property (input_detect_start);
	c_wd: cover property (watchdog_expired);
endmodule

bind ccs_regs ccs_regs_props i_props (.sys_clk, .reset, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
	.reg_rdata, .reg_rd_valid, .input_power_present, .input_source_status, .charge_state_status,
	.power_good_flag, .thermal_regulation_flag, .system_minimum_flag, .term_enable,
	.input_overvoltage_select, .input_detect_start, .safety_timer_reset, .watchdog_expired);

// [testbench/ccs_regs_tb.sv]
`timescale 1ns/100ps
module ccs_regs_tb;
	// short second so watchdog and switch delay fit the run
	localparam int TPS = 10;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        reg_wr_en = 1'b0;
	logic        reg_rd_en = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata, d;
	logic        input_power_present = 1'b1, power_good_flag = 1'b0, thermal_regulation_flag = 1'b0;
	logic        system_minimum_flag = 1'b0, input_limit_active = 1'b0, cool_zone = 1'b0, warm_zone = 1'b0;
	logic [2:0]  input_source_status = 3'h0;
	logic [1:0]  charge_state_status = 2'h0;
	logic [12:0] battery_mv = 13'd3800;
	logic        detect_done, reg_rd_valid, term_enable, safety_timer_half_rate, warm_voltage_cap;
	logic        battery_switch_off, input_detect_start, safety_timer_reset, watchdog_expired;
	logic [1:0]  input_overvoltage_select;
	logic [13:0] effective_vin_limit_mv;
	logic        safety_timer_enable, fast_charge_limit_select, thermal_threshold_select;
	logic        cold_zone_current_select, battery_switch_reset_enable;
	logic [1:0]  boost_voltage_select;
	logic [3:0]  input_voltage_limit;
	integer      seed = 32'h2413, failures = 0, tests_run = 0, cyc = 0, i, wd_seen = 0;

	always #4 sys_clk = ~sys_clk;

	ccs_core_model i_core (.sys_clk, .reset, .input_detect_start, .slow(1'b1), .detect_done);

	ccs_regs #(.TICKS_PER_SEC(TPS)) i_dut (.sys_clk, .reset, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rd_valid, .input_power_present, .detect_done, .input_source_status,
		.charge_state_status, .power_good_flag, .thermal_regulation_flag, .system_minimum_flag,
		.input_limit_active, .cool_zone, .warm_zone, .battery_mv, .term_enable, .safety_timer_enable,
		.fast_charge_limit_select, .thermal_threshold_select, .cold_zone_current_select,
		.input_overvoltage_select, .boost_voltage_select, .input_voltage_limit, .effective_vin_limit_mv,
		.safety_timer_half_rate, .warm_voltage_cap, .battery_switch_reset_enable, .battery_switch_off,
		.input_detect_start, .safety_timer_reset, .watchdog_expired);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		@(negedge sys_clk);
		chk({15'h0, reg_rd_valid}, 16'h1);
		chk({8'h0, reg_rdata}, {8'h0, e});
	endtask

	task automatic settle;
		repeat (3) @(negedge sys_clk);
	endtask

	function automatic logic [15:0] vlim(input logic [3:0] c, input logic [1:0] t, input logic [12:0] b);
		logic [15:0] r, k;
		r = 16'd3900 + 16'd100 * c;
		k = (t == 2'h0) ? 16'h0 : b + ((t == 2'h1) ? 16'd200 : (t == 2'h2) ? 16'd250 : 16'd300);
		return (k > r) ? k : r;
	endfunction

	task complete_run;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (watchdog_expired)
			wd_seen <= wd_seen + 1;
		if (cyc == 5000) begin
			failures++;
			complete_run();
		end
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		rd(8'h05, 8'h9f);
		rd(8'h06, 8'h66);
		rd(8'h07, 8'h4c);
		rd(8'h20, 8'h00);
		chk({2'h0, effective_vin_limit_mv}, 16'd4500);
		// frequent writes keep the watchdog fed
		for (i = 0; i < 12; i++) begin
			d = 8'($random(seed));
			wr(8'h06, d);
			settle();
			chk({14'h0, input_overvoltage_select}, {14'h0, d[7:6]});
			chk({2'h0, effective_vin_limit_mv}, vlim(d[3:0], 2'h0, battery_mv));
			chk({12'h0, input_voltage_limit}, {12'h0, d[3:0]});
			chk({14'h0, boost_voltage_select}, {14'h0, d[5:4]});
			d = 8'($random(seed));
			wr(8'h05, d);
			settle();
			chk({15'h0, term_enable}, {15'h0, d[7]});
			chk({15'h0, safety_timer_enable}, {15'h0, d[3]});
			chk({13'h0, fast_charge_limit_select, thermal_threshold_select, cold_zone_current_select},
				{13'h0, d[2:0]});
			rd(8'h05, d);
		end
		for (i = 0; i < 12; i++) begin
			@(posedge sys_clk);
			{input_source_status, charge_state_status, power_good_flag, thermal_regulation_flag,
				system_minimum_flag} <= 8'($random(seed));
			{warm_zone, cool_zone, input_limit_active} <= 3'($random(seed));
			wr(8'h08, 8'hff);
			rd(8'h08, {input_source_status, charge_state_status, power_good_flag, thermal_regulation_flag,
				system_minimum_flag});
			chk({15'h0, warm_voltage_cap}, {15'h0, warm_zone});
			chk({15'h0, safety_timer_half_rate},
				{15'h0, input_limit_active | cool_zone | thermal_regulation_flag});
		end
		wr(8'h0b, 8'h80);
		rd(8'h06, 8'h66);
		@(posedge sys_clk);
		input_power_present <= 1'b0;
		wr(8'h07, 8'hcc);
		rd(8'h07, 8'h4c);
		@(posedge sys_clk);
		input_power_present <= 1'b1;
		wr(8'h07, 8'hcc);
		rd(8'h07, 8'hcc);
		repeat (30) @(posedge sys_clk);
		rd(8'h07, 8'h4c);
		wr(8'h07, 8'h64);
		settle();
		chk({15'h0, battery_switch_off}, 16'h1);
		wr(8'h07, 8'h4c);
		settle();
		chk({15'h0, battery_switch_off}, 16'h0);
		wr(8'h07, 8'h6c);
		repeat (5 * TPS) @(negedge sys_clk);
		chk({15'h0, battery_switch_off}, 16'h0);
		repeat (7 * TPS) @(negedge sys_clk);
		chk({15'h0, battery_switch_off}, 16'h1);
		@(posedge sys_clk);
		battery_mv <= 13'd4400;
		wr(8'h07, 8'h4f);
		settle();
		chk({2'h0, effective_vin_limit_mv}, vlim(4'h6, 2'h3, 13'd4400));
		@(posedge sys_clk);
		battery_mv <= 13'd4000;
		settle();
		chk({2'h0, effective_vin_limit_mv}, vlim(4'h6, 2'h3, 13'd4000));
		wr(8'h06, 8'ha5);
		wr(8'h07, 8'h1b);
		wr(8'h05, 8'h1e);
		repeat (38 * TPS) @(posedge sys_clk);
		chk(wd_seen[15:0], 16'h0);
		chk({15'h0, battery_switch_reset_enable}, 16'h0);
		repeat (4 * TPS) @(posedge sys_clk);
		chk(wd_seen[15:0], 16'h1);
		rd(8'h05, 8'h9f);
		rd(8'h06, 8'ha5);
		rd(8'h07, 8'h4f);
		chk({15'h0, battery_switch_reset_enable}, 16'h1);
		// 80 s period, then code 00 stops the watchdog
		wr(8'h05, 8'ha0);
		repeat (78 * TPS) @(posedge sys_clk);
		chk(wd_seen[15:0], 16'h1);
		repeat (4 * TPS) @(posedge sys_clk);
		chk(wd_seen[15:0], 16'h2);
		wr(8'h05, 8'h80);
		repeat (42 * TPS) @(posedge sys_clk);
		chk(wd_seen[15:0], 16'h2);
		complete_run();
	end
endmodule
